// file: logic/pir_axil_slave.sv
`timescale 1ns/10ps
`default_nettype none
// axi4-lite write slave: captures aw and w in either order, one write at a time
module pir_axil_slave
	import pir_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// write channels
	input  wire logic [7:0] s_axi_awaddr,
	input  wire logic       s_axi_awvalid,
	output logic            s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0] s_axi_wstrb,
	input  wire logic       s_axi_wvalid,
	output logic            s_axi_wready,
	output logic [1:0]      s_axi_bresp,
	output logic            s_axi_bvalid,
	input  wire logic       s_axi_bready,
	// register write port
	pir_wr_if.slave         wr
);
	logic       aw_have_reg, aw_have_next;
	logic       w_have_reg, w_have_next;
	logic [7:0] aw_idx_reg, aw_idx_next;
	logic [7:0] w_data_reg, w_data_next;
	logic       w_lane_reg, w_lane_next;
	logic       bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;

	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready  = !w_have_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;

	// commit when both halves are held; response follows the commit
	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next  = w_have_reg;
		aw_idx_next  = aw_idx_reg;
		w_data_next  = w_data_reg;
		w_lane_next  = w_lane_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		wr.wr_en     = 1'b0;
		wr.wr_idx    = aw_idx_reg;
		wr.wr_data   = w_data_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_next = 1'b1;
			aw_idx_next  = pir_index(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_next = 1'b1;
			w_data_next = s_axi_wdata[7:0];
			w_lane_next = s_axi_wstrb[0];
		end
		if (aw_have_reg && w_have_reg) begin
			// a write without lane 0 leaves the register untouched
			wr.wr_en     = w_lane_reg;
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = (aw_idx_reg <= PIR_IDX_CAUSE) ?
				PIR_RESP_OKAY : PIR_RESP_SLVERR;
		end
		if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			aw_idx_reg  <= 8'h00;
			w_data_reg  <= 8'h00;
			w_lane_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= PIR_RESP_OKAY;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg  <= w_have_next;
			aw_idx_reg  <= aw_idx_next;
			w_data_reg  <= w_data_next;
			w_lane_reg  <= w_lane_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
		end
	end

	chk_bvalid_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bvalid_reg && !s_axi_bready |=> bvalid_reg)
		else $error("write response dropped before bready");
	cov_write_done: cover property (@(posedge ref_clk) disable iff (sys_rst)
		bvalid_reg && s_axi_bready);
endmodule
`default_nettype wire

// file: logic/pir_pkg.sv
// Behaviour
// RL1: 12-bit part id: bits 7:0 in identity_low, bits 11:8 low nibble of high.
// RL2: identity_high holds 2-bit silicon revision at 7:6, variant code at 5:4.
// RL3: interrupt_flags at offset 02h, resets to zero, unused bits read-only.
// RL4: flag bit 7 sets on any rail power fault or critical die temperature.
// RL5: each flag stays set until host writes 1 there; writing 0 leaves it.
// RL6: flag bit 3 sets whenever the device performs a shutdown.
// RL7: shutdown flag clears only once every shutdown cause bit is clear.
// RL8: flag bit 0 sets when die temperature rises across the hot threshold.
// RL9: interrupt_mask at offset 03h resets to all ones, all events masked.
// RL10: mask bits 7, 3, 0 mask their flag when 1; other mask bits read-only.
// RL11: setting any shutdown cause bit also sets the shutdown flag.
// RL12: status at 04h bit 0 shows live die temperature above hot threshold.
// RL13: interrupt output active while any flag set with its mask bit 0.
// RL14: reserved flag and mask bit positions ignore writes.
package pir_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] PIR_IDX_ID_LOW   = 8'h00;
	localparam logic [7:0] PIR_IDX_ID_HIGH  = 8'h01;
	localparam logic [7:0] PIR_IDX_FLAGS    = 8'h02;
	localparam logic [7:0] PIR_IDX_MASK     = 8'h03;
	localparam logic [7:0] PIR_IDX_STATUS   = 8'h04;
	localparam logic [7:0] PIR_IDX_CAUSE    = 8'h05;
	// field positions
	localparam int PIR_BIT_FAULT    = 7;
	localparam int PIR_BIT_SHUTDOWN = 3;
	localparam int PIR_BIT_DIE_HOT  = 0;
	localparam int PIR_BIT_LIVE_HOT = 0;
	localparam logic [7:0] PIR_FLAG_WMASK  = 8'h89;
	localparam logic [3:0] PIR_CAUSE_WMASK = 4'hf;
	// reset values
	localparam logic [7:0] PIR_FLAGS_RST = 8'h00;
	localparam logic [7:0] PIR_MASK_RST  = 8'hff;
	localparam logic [3:0] PIR_CAUSE_RST = 4'h0;
	// axi responses
	localparam logic [1:0] PIR_RESP_OKAY   = 2'b00;
	localparam logic [1:0] PIR_RESP_SLVERR = 2'b10;
	// byte address to register index
	function automatic logic [7:0] pir_index(input logic [7:0] addr);
		return {2'b00, addr[7:2]};
	endfunction
endpackage

// file: logic/pir_regs.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
// identification and interrupt registers of the power manager
module pir_regs
	import pir_pkg::*;
#(
	parameter logic [11:0] PART_ID     = 12'h0a5, // arbitrary value
	parameter logic [1:0]  SILICON_REV = 2'h0,    // arbitrary value
	parameter logic [1:0]  VARIANT     = 2'h0     // arbitrary value
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// event inputs from the device core, one-cycle pulses
	input  wire logic        rail_fault_evt,
	input  wire logic        crit_temp_evt,
	input  wire logic        uvlo_evt,
	input  wire logic        unmasked_fault_shdn_evt,
	input  wire logic        crit_temp_shdn_evt,
	input  wire logic        shutdown_evt,
	// live die temperature level
	input  wire logic        die_hot_level,
	// interrupt output, active low
	output logic             irq_n
);
	pir_wr_if wr ();

	logic [7:0]  flags_reg, flags_next;
	logic [7:0]  mask_reg, mask_next;
	logic [3:0]  cause_reg, cause_next;
	logic        hot_prev_reg, hot_prev_next;
	logic        irq_n_reg, irq_n_next;
	logic        rvalid_reg, rvalid_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [7:0]  set_vec;
	logic [7:0]  clr_vec;
	logic [3:0]  cause_set;
	logic        hot_rise;

	pir_axil_slave u_slave (
		.ref_clk       (ref_clk),
		.sys_rst       (sys_rst),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.wr            (wr)
	);

	// event decoding; cause bits 2:0 are uvlo, fault, critical temperature
	always_comb begin
		hot_rise     = die_hot_level && !hot_prev_reg; // RL8
		cause_set    = 4'h0;
		cause_set[2] = uvlo_evt;
		cause_set[1] = unmasked_fault_shdn_evt;
		cause_set[0] = crit_temp_shdn_evt;
		set_vec      = 8'h00;
		set_vec[PIR_BIT_FAULT]    = rail_fault_evt || crit_temp_evt; // RL4
		// any cause bit being set also raises the shutdown flag
		set_vec[PIR_BIT_SHUTDOWN] = shutdown_evt || (|cause_set); // RL6 RL11
		set_vec[PIR_BIT_DIE_HOT]  = hot_rise; // RL8
		clr_vec = 8'h00;
		if (wr.wr_en && wr.wr_idx == PIR_IDX_FLAGS)
			clr_vec = wr.wr_data & PIR_FLAG_WMASK; // RL5 RL14
		// shutdown flag holds while any cause is still recorded
		if (cause_reg != PIR_CAUSE_RST)
			clr_vec[PIR_BIT_SHUTDOWN] = 1'b0; // RL7
	end

	// register file next state; a set in the clear cycle wins
	always_comb begin
		flags_next    = (flags_reg & ~clr_vec) | set_vec; // RL5
		mask_next     = mask_reg;
		cause_next    = cause_reg;
		hot_prev_next = die_hot_level;
		if (wr.wr_en && wr.wr_idx == PIR_IDX_MASK)
			mask_next = (mask_reg & ~PIR_FLAG_WMASK) |
				(wr.wr_data & PIR_FLAG_WMASK); // RL10 RL14
		if (wr.wr_en && wr.wr_idx == PIR_IDX_CAUSE)
			cause_next = cause_reg & ~(wr.wr_data[3:0] & PIR_CAUSE_WMASK);
		cause_next = cause_next | cause_set;
		// registered so the pin never glitches on decode
		irq_n_next = !(|(flags_next & ~mask_next & PIR_FLAG_WMASK)); // RL13
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flags_reg    <= PIR_FLAGS_RST; // RL3
			mask_reg     <= PIR_MASK_RST; // RL9
			cause_reg    <= PIR_CAUSE_RST;
			hot_prev_reg <= 1'b0;
			irq_n_reg    <= 1'b1;
		end else begin
			flags_reg    <= flags_next;
			mask_reg     <= mask_next;
			cause_reg    <= cause_next;
			hot_prev_reg <= hot_prev_next;
			irq_n_reg    <= irq_n_next;
		end
	end
	assign irq_n = irq_n_reg;

	// read channel: one read at a time, data one cycle after address
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = {24'h000000, rdata_reg};
	assign s_axi_rresp   = rresp_reg;

	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next  = rdata_reg;
		rresp_next  = rresp_reg;
		if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
		if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = PIR_RESP_OKAY;
			unique case (pir_index(s_axi_araddr))
				PIR_IDX_ID_LOW:  rdata_next = PART_ID[7:0]; // RL1
				PIR_IDX_ID_HIGH: rdata_next = {SILICON_REV, VARIANT,
					PART_ID[11:8]}; // RL1 RL2
				PIR_IDX_FLAGS:   rdata_next = flags_reg;
				PIR_IDX_MASK:    rdata_next = mask_reg;
				PIR_IDX_STATUS:  rdata_next = {7'h00, die_hot_level}; // RL12
				PIR_IDX_CAUSE:   rdata_next = {4'h0, cause_reg};
				default: begin
					rdata_next = 8'h00;
					rresp_next = PIR_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 8'h00;
			rresp_reg  <= PIR_RESP_OKAY;
		end else begin
			rvalid_reg <= rvalid_next;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rresp_next;
		end
	end

	// reset values and reserved bits
	chk_reserved_flags_zero: assert property (@(posedge ref_clk) // RL14
		disable iff (sys_rst) (flags_reg & ~PIR_FLAG_WMASK) == 8'h00)
		else $error("reserved flag bit set");
	chk_reset_flags_clear: assert property (@(posedge ref_clk) // RL3
		$past(sys_rst) |-> flags_reg == PIR_FLAGS_RST)
		else $error("flags not clear after reset");
	chk_reset_mask_ones: assert property (@(posedge ref_clk) // RL9
		$past(sys_rst) |-> mask_reg == PIR_MASK_RST)
		else $error("mask not all ones after reset");
	chk_mask_reserved: assert property (@(posedge ref_clk) // RL10
		disable iff (sys_rst)
		(mask_reg & ~PIR_FLAG_WMASK) == (PIR_MASK_RST & ~PIR_FLAG_WMASK))
		else $error("reserved mask bit changed");

	// events set their flags
	chk_fault_sets_flag: assert property (@(posedge ref_clk) // RL4
		disable iff (sys_rst)
		rail_fault_evt || crit_temp_evt |=> flags_reg[PIR_BIT_FAULT])
		else $error("fault event did not set flag");
	chk_shutdown_sets_flag: assert property (@(posedge ref_clk) // RL6
		disable iff (sys_rst)
		shutdown_evt || (|cause_set) |=> flags_reg[PIR_BIT_SHUTDOWN])
		else $error("shutdown did not set flag");
	chk_cause_sets_shdn: assert property (@(posedge ref_clk) // RL11
		disable iff (sys_rst) $rose(cause_reg[2]) ||
		$rose(cause_reg[1]) || $rose(cause_reg[0])
		|-> flags_reg[PIR_BIT_SHUTDOWN])
		else $error("cause without shutdown flag");
	chk_hot_rise_flag: assert property (@(posedge ref_clk) // RL8
		disable iff (sys_rst) die_hot_level && !hot_prev_reg
		|=> flags_reg[PIR_BIT_DIE_HOT])
		else $error("hot crossing not flagged");
	// a steady hot level must not raise the flag again after a clear
	chk_hot_level_quiet: assert property (@(posedge ref_clk) // RL8
		disable iff (sys_rst) !flags_reg[PIR_BIT_DIE_HOT] &&
		!(die_hot_level && !hot_prev_reg) |=> !flags_reg[PIR_BIT_DIE_HOT])
		else $error("die hot flag set without a rising crossing");

	// flags clear only on a write of one
	chk_flag_sticky: assert property (@(posedge ref_clk) // RL5
		disable iff (sys_rst) flags_reg[PIR_BIT_DIE_HOT] &&
		!(wr.wr_en && wr.wr_idx == PIR_IDX_FLAGS)
		|=> flags_reg[PIR_BIT_DIE_HOT])
		else $error("flag dropped without clear");
	chk_zero_write_keeps: assert property (@(posedge ref_clk) // RL5
		disable iff (sys_rst) flags_reg[PIR_BIT_FAULT] &&
		!(wr.wr_en && wr.wr_idx == PIR_IDX_FLAGS &&
		wr.wr_data[PIR_BIT_FAULT]) |=> flags_reg[PIR_BIT_FAULT])
		else $error("fault flag dropped without a write of one");
	chk_fault_w1c: assert property (@(posedge ref_clk) // RL5
		disable iff (sys_rst) wr.wr_en && wr.wr_idx == PIR_IDX_FLAGS &&
		wr.wr_data[PIR_BIT_FAULT] && !rail_fault_evt && !crit_temp_evt
		|=> !flags_reg[PIR_BIT_FAULT])
		else $error("fault flag survived a write of one");
	chk_cause_holds_shdn: assert property (@(posedge ref_clk) // RL7
		disable iff (sys_rst) cause_reg != PIR_CAUSE_RST &&
		flags_reg[PIR_BIT_SHUTDOWN] |=> flags_reg[PIR_BIT_SHUTDOWN])
		else $error("shutdown flag cleared with cause pending");
	chk_shdn_clear_free: assert property (@(posedge ref_clk) // RL7
		disable iff (sys_rst) wr.wr_en && wr.wr_idx == PIR_IDX_FLAGS &&
		wr.wr_data[PIR_BIT_SHUTDOWN] && cause_reg == PIR_CAUSE_RST &&
		!shutdown_evt && !(|cause_set) |=> !flags_reg[PIR_BIT_SHUTDOWN])
		else $error("shutdown flag kept with no cause pending");
	chk_cause_clear: assert property (@(posedge ref_clk)
		disable iff (sys_rst) wr.wr_en && wr.wr_idx == PIR_IDX_CAUSE &&
		!(|cause_set)
		|=> (cause_reg & $past(wr.wr_data[3:0])) == 4'h0)
		else $error("cause bits not cleared by write");

	// mask and interrupt pin
	chk_mask_write_lands: assert property (@(posedge ref_clk) // RL10
		disable iff (sys_rst) wr.wr_en && wr.wr_idx == PIR_IDX_MASK
		|=> (mask_reg & PIR_FLAG_WMASK) ==
		($past(wr.wr_data) & PIR_FLAG_WMASK))
		else $error("mask write did not land");
	chk_mask_only_by_write: assert property (@(posedge ref_clk) // RL10
		disable iff (sys_rst)
		!(wr.wr_en && wr.wr_idx == PIR_IDX_MASK) |=> $stable(mask_reg))
		else $error("mask changed without a mask write");
	chk_irq_follows: assert property (@(posedge ref_clk) // RL13
		disable iff (sys_rst)
		irq_n == !(|(flags_reg & ~mask_reg & PIR_FLAG_WMASK)))
		else $error("interrupt pin does not match flags");

	// read data
	chk_id_low_read: assert property (@(posedge ref_clk) // RL1
		disable iff (sys_rst) s_axi_arvalid && s_axi_arready &&
		pir_index(s_axi_araddr) == PIR_IDX_ID_LOW
		|=> s_axi_rdata == {24'h000000, PART_ID[7:0]})
		else $error("low identity read wrong");
	chk_id_read: assert property (@(posedge ref_clk) // RL2
		disable iff (sys_rst) s_axi_arvalid && s_axi_arready &&
		pir_index(s_axi_araddr) == PIR_IDX_ID_HIGH
		|=> s_axi_rdata[7:0] == {SILICON_REV, VARIANT, PART_ID[11:8]})
		else $error("identity read wrong");
	chk_flags_read: assert property (@(posedge ref_clk) // RL3
		disable iff (sys_rst) s_axi_arvalid && s_axi_arready &&
		pir_index(s_axi_araddr) == PIR_IDX_FLAGS
		|=> s_axi_rdata == {24'h000000, $past(flags_reg)})
		else $error("flag register read wrong");
	chk_mask_read: assert property (@(posedge ref_clk) // RL9
		disable iff (sys_rst) s_axi_arvalid && s_axi_arready &&
		pir_index(s_axi_araddr) == PIR_IDX_MASK
		|=> s_axi_rdata == {24'h000000, $past(mask_reg)})
		else $error("mask register read wrong");
	chk_cause_read: assert property (@(posedge ref_clk) // RL11
		disable iff (sys_rst) s_axi_arvalid && s_axi_arready &&
		pir_index(s_axi_araddr) == PIR_IDX_CAUSE
		|=> s_axi_rdata == {28'h0000000, $past(cause_reg)})
		else $error("cause register read wrong");
	chk_status_live: assert property (@(posedge ref_clk) // RL12
		disable iff (sys_rst) s_axi_arvalid && s_axi_arready &&
		pir_index(s_axi_araddr) == PIR_IDX_STATUS
		|=> s_axi_rdata[0] == $past(die_hot_level))
		else $error("status read not live");
	chk_unmapped_read: assert property (@(posedge ref_clk)
		disable iff (sys_rst) s_axi_arvalid && s_axi_arready &&
		pir_index(s_axi_araddr) > PIR_IDX_CAUSE
		|=> s_axi_rresp == PIR_RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");

	// main scenarios
	cov_irq_asserted: cover property (@(posedge ref_clk) !irq_n);
	cov_shdn_cleared: cover property (@(posedge ref_clk)
		$fell(flags_reg[PIR_BIT_SHUTDOWN]));
	cov_read_done: cover property (@(posedge ref_clk) rvalid_reg && s_axi_rready);
	// host tries the shutdown flag before its causes are gone
	cov_cause_blocks: cover property (@(posedge ref_clk)
		disable iff (sys_rst) wr.wr_en && wr.wr_idx == PIR_IDX_FLAGS &&
		wr.wr_data[PIR_BIT_SHUTDOWN] && cause_reg != PIR_CAUSE_RST);
endmodule
`default_nettype wire

// file: logic/pir_wr_if.sv
`timescale 1ns/10ps
`default_nettype none
// one accepted register write between the bus slave and the register file
interface pir_wr_if;
	logic       wr_en;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;
	modport slave (output wr_en, output wr_idx, output wr_data);
	modport regs  (input wr_en, input wr_idx, input wr_data);
endinterface
`default_nettype wire

// file: test/pir_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// axi4-lite master standing in for the host processor
module pir_host_model (
	// clock
	input  wire logic        ref_clk,
	// write channels
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	// read channels
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// idle bus at time zero
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
		s_axi_wstrb = 4'h0;
	end
	// handshakes are sampled at the falling edge, where nothing moves,
	// and acted on by nba after the next rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic aw_t, w_t, b_t, bv_t;
		@(posedge ref_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h000000, d};
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		b_t = 1'b0;
		while (!b_t) begin
			@(negedge ref_clk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t  = s_axi_wvalid && s_axi_wready;
			b_t  = s_axi_bvalid && s_axi_bready;
			bv_t = s_axi_bvalid;
			r    = s_axi_bresp;
			@(posedge ref_clk);
			// released lines stop showing the old payload
			if (aw_t) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr  <= ~a;
			end
			if (w_t) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata  <= ~{24'h000000, d};
			end
			// bready trails bvalid by a cycle, so the slave must hold it
			if (bv_t && !b_t)
				s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
	endtask
	// one read, waits however long the slave takes
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_t, r_t;
		@(posedge ref_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		r_t = 1'b0;
		while (!r_t) begin
			@(negedge ref_clk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t  = s_axi_rvalid && s_axi_rready;
			d    = s_axi_rdata;
			r    = s_axi_rresp;
			@(posedge ref_clk);
			if (ar_t) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr  <= ~a;
			end
		end
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// file: test/pir_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
// self-checking bench for the id and interrupt registers
module pir_regs_test
	import pir_pkg::*;
;
	localparam logic [11:0] PID = 12'h3c7; // arbitrary value
	localparam logic [1:0]  REV = 2'h2;    // arbitrary value
	localparam logic [1:0]  VAR = 2'h1;    // arbitrary value
	logic        ref_clk, sys_rst, hot, irq_n;
	logic [5:0]  evt;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rv;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	int          err_total, total_checks, cyc, i;

	pir_regs #(.PART_ID(PID), .SILICON_REV(REV), .VARIANT(VAR)) i_pir_regs (
		.ref_clk(ref_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rail_fault_evt(evt[0]), .crit_temp_evt(evt[1]), .uvlo_evt(evt[2]),
		.unmasked_fault_shdn_evt(evt[3]), .crit_temp_shdn_evt(evt[4]),
		.shutdown_evt(evt[5]), .die_hot_level(hot), .irq_n(irq_n));

	pir_host_model i_pir_host_model (
		.ref_clk(ref_clk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// 50 mhz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// verdict, reached from the main sequence or the hang guard
	task wrap_up;
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// register access by index; byte address is four times the index
	task w(input logic [7:0] idx, input logic [7:0] d);
		i_pir_host_model.wr({idx[5:0], 2'b00}, d, 4'h1, rs);
	endtask
	task rc(input logic [7:0] idx, input logic [7:0] exp);
		i_pir_host_model.rd({idx[5:0], 2'b00}, rv, rs);
		chk(rv, {24'h000000, exp});
	endtask
	// one-cycle event pulse from the device core
	task pulse(input int b);
		@(posedge ref_clk);
		evt[b] <= 1'b1;
		@(posedge ref_clk);
		evt <= 6'h00;
	endtask
	// irq_n is registered on the same edge as the flag; let two edges pass
	task irqc(input logic e);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk({31'h0, irq_n}, {31'h0, e});
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			wrap_up;
		end
	end
	// main sequence
	initial begin
		sys_rst = 1'b1;
		evt = 6'h00;
		hot = 1'b0;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rc(PIR_IDX_ID_LOW, PID[7:0]);
		rc(PIR_IDX_ID_HIGH, {REV, VAR, PID[11:8]});
		rc(PIR_IDX_FLAGS, 8'h00);
		rc(PIR_IDX_MASK, 8'hff);
		// a write with lane 0 off leaves the register as it was
		i_pir_host_model.wr({PIR_IDX_MASK[5:0], 2'b00}, 8'h00, 4'h0, rs);
		rc(PIR_IDX_MASK, 8'hff);
		w(PIR_IDX_ID_HIGH, 8'h00);
		rc(PIR_IDX_ID_HIGH, {REV, VAR, PID[11:8]});
		w(PIR_IDX_FLAGS, 8'hff);
		rc(PIR_IDX_FLAGS, 8'h00);
		// fault flag from both sources; clearing needs a 1 in bit 7
		for (i = 0; i < 2; i++) begin
			pulse(i);
			rc(PIR_IDX_FLAGS, 8'h80);
			irqc(1'b1);
			w(PIR_IDX_FLAGS, 8'h09);
			rc(PIR_IDX_FLAGS, 8'h80);
			w(PIR_IDX_FLAGS, 8'h80);
			rc(PIR_IDX_FLAGS, 8'h00);
		end
		// unmasking a pending flag drives the interrupt, masking drops it
		pulse(0);
		w(PIR_IDX_MASK, 8'h00);
		rc(PIR_IDX_MASK, 8'h76);
		irqc(1'b0);
		w(PIR_IDX_MASK, 8'hff);
		irqc(1'b1);
		w(PIR_IDX_MASK, 8'h00);
		w(PIR_IDX_FLAGS, 8'h80);
		irqc(1'b1);
		// die temperature: a rise sets the flag, a steady level does not
		@(posedge ref_clk);
		hot <= 1'b1;
		rc(PIR_IDX_FLAGS, 8'h01);
		rc(PIR_IDX_STATUS, 8'h01);
		irqc(1'b0);
		w(PIR_IDX_FLAGS, 8'h01);
		rc(PIR_IDX_FLAGS, 8'h00);
		hot <= 1'b0;
		rc(PIR_IDX_STATUS, 8'h00);
		pulse(5);
		rc(PIR_IDX_FLAGS, 8'h08);
		w(PIR_IDX_FLAGS, 8'h08);
		rc(PIR_IDX_FLAGS, 8'h00);
		// each cause sets the shutdown flag, which holds until causes clear
		for (i = 2; i < 5; i++) begin
			pulse(i);
			rc(PIR_IDX_CAUSE, 8'h01 << (4 - i));
			rc(PIR_IDX_FLAGS, 8'h08);
			w(PIR_IDX_FLAGS, 8'h08);
			rc(PIR_IDX_FLAGS, 8'h08);
			w(PIR_IDX_CAUSE, 8'h01 << (4 - i));
			w(PIR_IDX_FLAGS, 8'h08);
			rc(PIR_IDX_FLAGS, 8'h00);
		end
		// unmapped place answers with an error and reads zero
		i_pir_host_model.wr(8'h18, 8'hff, 4'h1, rs);
		chk({30'h0, rs}, {30'h0, PIR_RESP_SLVERR});
		i_pir_host_model.rd(8'h18, rv, rs);
		chk({rv[29:0], rs}, {30'h0, PIR_RESP_SLVERR});
		wrap_up;
	end
endmodule
`default_nettype wire
